// ---- common/axb_consts.svh ----
`ifndef AXB_CONSTS_SVH
`define AXB_CONSTS_SVH

// AXI burst and response encodings
`define AXB_BURST_INCR  2'h1
`define AXB_RESP_OKAY   2'h0
`define AXB_RESP_SLVERR 2'h2
`define AXB_RESP_DECERR 2'h3

// Completion status encodings
`define AXB_CPL_SC      3'h0
`define AXB_CPL_UR      3'h1
`define AXB_CPL_CRS     3'h2
`define AXB_CPL_CA      3'h4

// Timing
`define AXB_CLK_MHZ     125
`define AXB_CFG_TMO_US  50
`define AXB_CFG_TMO_CYC (`AXB_CFG_TMO_US * `AXB_CLK_MHZ)
`define AXB_TMR_W       24

// Filler read data for error answers
`define AXB_DATA_ONES   32'hffff_ffff

`endif

// ---- common/axb_pkg.sv ----
package axb_pkg;

	typedef enum logic [1:0] {
		AXB_MRD,
		AXB_MWR,
		AXB_CFGRD,
		AXB_CFGWR
	} axb_kind_t;

	typedef struct packed {
		axb_kind_t   kind;
		logic [7:0]  tag;
		logic [31:0] addr;
		logic [7:0]  len;
		logic [31:0] data;
		logic        last;
	} axb_req_t;

	typedef struct packed {
		logic [15:0] req_id;
		logic [7:0]  tag;
		logic [2:0]  status;
		logic        poisoned;
		logic [31:0] data;
		logic        last;
	} axb_cpl_t;

	typedef struct packed {
		logic       is_write;
		logic       is_cfg;
		logic [3:0] id;
		logic [7:0] len;
	} axb_ent_t;

endpackage : axb_pkg

// ---- rtl/axb_cpl_timer.sv ----
`timescale 1ns/100ps
`include "axb_consts.svh"

module axb_cpl_timer
	import axb_pkg::*;
#(
	parameter int TW = `AXB_TMR_W
) (
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	input  wire logic          run_i,
	input  wire logic [TW-1:0] limit_i,
	output logic               expired_o
);

	logic [TW-1:0] cnt_q;

	always_ff @(posedge mclk_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= '0;
		end else if (cnt_q != limit_i) begin
			cnt_q <= cnt_q + {{(TW-1){1'b0}}, 1'b1};
		end
	end

	assign expired_o = run_i && (cnt_q == limit_i);

	a_tmr_limit: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(expired_o) |-> run_i && $past(run_i) && cnt_q == limit_i)
		else $error("timer expired before its limit");

endmodule : axb_cpl_timer

// ---- rtl/axb_tag_table.sv ----
`timescale 1ns/100ps
`include "axb_consts.svh"

module axb_tag_table
	import axb_pkg::*;
#(
	parameter int NENT = 4,
	parameter int IW   = $clog2(NENT)
) (
	input  wire logic            mclk_i,
	input  wire logic            rst_i,
	input  wire logic            alloc_i,
	input  wire axb_ent_t        alloc_ent_i,
	input  wire logic            free_i,
	input  wire logic [IW-1:0]   free_idx_i,
	input  wire logic [15:0]     own_req_id_i,
	input  wire logic [15:0]     lk_req_id_i,
	input  wire logic [7:0]      lk_tag_i,
	input  wire logic [IW-1:0]   rd_idx_i,
	output logic                 hit_o,
	output logic [IW-1:0]        hit_idx_o,
	output axb_ent_t             hit_ent_o,
	output axb_ent_t             rd_ent_o,
	output logic                 any_free_o,
	output logic [IW-1:0]        free_slot_o,
	output logic [NENT-1:0]      valid_o
);

	axb_ent_t        ent_q [NENT];
	logic [NENT-1:0] valid_q;

	always_comb begin
		any_free_o  = 1'b0;
		free_slot_o = '0;
		for (int i = NENT - 1; i >= 0; i--) begin
			if (!valid_q[i]) begin
				any_free_o  = 1'b1;
				free_slot_o = IW'(i);
			end
		end
	end

	// Tag is the slot index, so the match is a direct index check
	always_comb begin
		hit_idx_o = lk_tag_i[IW-1:0];
		hit_o     = (lk_req_id_i == own_req_id_i) && (lk_tag_i < 8'(NENT))
			&& valid_q[lk_tag_i[IW-1:0]];
		hit_ent_o = ent_q[lk_tag_i[IW-1:0]];
	end

	assign rd_ent_o = ent_q[rd_idx_i];
	assign valid_o  = valid_q;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			valid_q <= '0;
		end else begin
			if (free_i) begin
				valid_q[free_idx_i] <= 1'b0;
			end
			if (alloc_i) begin
				valid_q[free_slot_o] <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (alloc_i) begin
			ent_q[free_slot_o] <= alloc_ent_i;
		end
	end

	a_match_valid: assert property (@(posedge mclk_i) disable iff (rst_i)
		hit_o |-> valid_q[hit_idx_o] && lk_req_id_i == own_req_id_i)
		else $error("completion matched a free slot");

endmodule : axb_tag_table

// ---- rtl/axb_bridge_err.sv ----
`timescale 1ns/100ps
`include "axb_consts.svh"

// What this block does
// - Any AXI burst type other than incrementing is an illegal burst, with a strobe.
// - Illegal read burst: SLVERR on every beat, filler data, nothing forwarded.
// - Illegal write burst: all write data swallowed, SLVERR write response.
// - Non-posted requests wait for a completion; posted writes finish at once.
// - Each completion is matched on requester ID and tag against outstanding slots.
// - Unmatched completion is dropped with a strobe; other traffic carries on.
// - Unsupported Request status: strobe, DECERR answer with filler data.
// - Reserved status encodings are handled as Unsupported Request.
// - Config requests time out after a fixed parameter cycle count from issue.
// - Memory reads time out after the count derived from Device Control 2.
// - Timeout: strobe and end the request (read or config write); response code chosen by parameter.
// - Poisoned completion: data dropped, strobe, SLVERR with filler data.
// - Completer Abort status: strobe, SLVERR with filler data.
module axb_bridge_err
	import axb_pkg::*;
#(
	parameter int          NENT        = 4,
	parameter int          TW          = `AXB_TMR_W,
	parameter logic [23:0] CFG_TMO_CYC = 24'(`AXB_CFG_TMO_CYC),
	parameter bit          TMO_OKAY    = 1'b1
) (
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	input  wire logic [15:0]   own_req_id_i,
	input  wire logic [TW-1:0] mem_tmo_cyc_i,
	input  wire logic          s_axi_awvalid_i,
	output logic               s_axi_awready_o,
	input  wire logic [3:0]    s_axi_awid_i,
	input  wire logic [31:0]   s_axi_awaddr_i,
	input  wire logic [7:0]    s_axi_awlen_i,
	input  wire logic [1:0]    s_axi_awburst_i,
	input  wire logic          s_axi_awuser_i,
	input  wire logic          s_axi_wvalid_i,
	output logic               s_axi_wready_o,
	input  wire logic [31:0]   s_axi_wdata_i,
	input  wire logic          s_axi_wlast_i,
	output logic               s_axi_bvalid_o,
	input  wire logic          s_axi_bready_i,
	output logic [3:0]         s_axi_bid_o,
	output logic [1:0]         s_axi_bresp_o,
	input  wire logic          s_axi_arvalid_i,
	output logic               s_axi_arready_o,
	input  wire logic [3:0]    s_axi_arid_i,
	input  wire logic [31:0]   s_axi_araddr_i,
	input  wire logic [7:0]    s_axi_arlen_i,
	input  wire logic [1:0]    s_axi_arburst_i,
	input  wire logic          s_axi_aruser_i,
	output logic               s_axi_rvalid_o,
	input  wire logic          s_axi_rready_i,
	output logic [3:0]         s_axi_rid_o,
	output logic [31:0]        s_axi_rdata_o,
	output logic [1:0]         s_axi_rresp_o,
	output logic               s_axi_rlast_o,
	output logic               req_valid_o,
	input  wire logic          req_ready_i,
	output axb_req_t           req_o,
	input  wire logic          cpl_valid_i,
	output logic               cpl_ready_o,
	input  wire axb_cpl_t      cpl_i,
	output logic               illegal_burst_irq_o,
	output logic               unexpected_cpl_irq_o,
	output logic               unsupported_req_irq_o,
	output logic               cpl_timeout_irq_o,
	output logic               poisoned_cpl_irq_o,
	output logic               completer_abort_irq_o
);

	localparam int IW = $clog2(NENT);

	typedef enum logic [1:0] {S_IDLE, S_FWD, S_DROP, S_RESP} axb_eng_st_t;
	typedef enum logic [1:0] {W_IDLE, W_FWD, W_DISC} axb_wst_t;

	axb_eng_st_t     st_q;
	axb_wst_t        wst_q;
	logic            arp_q, arp_bad_q, arp_cfg_q;
	logic [3:0]      arp_id_q;
	logic [31:0]     arp_addr_q;
	logic [7:0]      arp_len_q;
	logic [3:0]      aw_id_q;
	logic [31:0]     aw_addr_q;
	logic [7:0]      aw_len_q;
	logic            aw_cfg_q, first_q;
	logic [IW-1:0]   aw_tag_q;
	logic [NENT-1:0] iss_q, cfg_q, valid, tmo;
	logic            tmo_any;
	logic [IW-1:0]   tmo_idx;
	logic            hit, any_free;
	logic [IW-1:0]   hit_idx, free_slot;
	axb_ent_t        hit_ent, tmo_ent;
	logic [7:0]      cnt_q;
	logic [1:0]      rsp_q;
	logic [3:0]      id_q;
	logic            wr_q, pend_q;
	logic            r_v_q, b_v_q, req_v_q;
	logic            ar_hs, ar_bad, aw_hs, aw_bad, aw_need;
	logic            req_free, r_free, b_free;
	logic            w_take, disc_take, wb_load, rd_issue, alloc, free;
	logic [IW-1:0]   free_idx;
	axb_ent_t        alloc_ent;
	logic            d_ib, d_tmo, d_cpl, d_unexp, d_ur, d_ca, d_ep, c_ur, c_ca;
	logic            eng_r_load, eng_b_load, cpl_take;
	logic [5:0]      irq_q;

	assign ar_bad   = s_axi_arburst_i != `AXB_BURST_INCR;
	assign aw_bad   = s_axi_awburst_i != `AXB_BURST_INCR;
	assign aw_need  = s_axi_awuser_i && !aw_bad;
	assign ar_hs    = s_axi_arvalid_i && s_axi_arready_o;
	assign aw_hs    = s_axi_awvalid_i && s_axi_awready_o;
	assign req_free = !req_v_q || req_ready_i;
	assign r_free   = !r_v_q || s_axi_rready_i;
	assign b_free   = !b_v_q || s_axi_bready_i;

	// One illegal burst per cycle keeps one strobe per request
	assign s_axi_arready_o = !arp_q;
	assign s_axi_awready_o = (wst_q == W_IDLE) && !(ar_hs && ar_bad)
		&& (!aw_need || any_free);

	assign w_take    = (wst_q == W_FWD) && s_axi_wvalid_i && req_free
		&& (!s_axi_wlast_i || aw_cfg_q || b_free);
	assign disc_take = (wst_q == W_DISC) && s_axi_wvalid_i && (!s_axi_wlast_i || b_free);
	assign s_axi_wready_o = w_take || disc_take;
	assign wb_load   = s_axi_wlast_i && ((w_take && !aw_cfg_q) || disc_take);

	assign rd_issue  = arp_q && !arp_bad_q && any_free && !(aw_hs && aw_need)
		&& req_free && (wst_q != W_FWD);
	assign alloc     = (aw_hs && aw_need) || rd_issue;
	assign alloc_ent = rd_issue ? axb_ent_t'{1'b0, arp_cfg_q, arp_id_q, arp_len_q}
		: axb_ent_t'{1'b1, 1'b1, s_axi_awid_i, s_axi_awlen_i};

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			arp_q <= 1'b0;
		end else if (ar_hs) begin
			arp_q <= 1'b1;
		end else if (rd_issue || d_ib) begin
			arp_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (ar_hs) begin
			arp_bad_q  <= ar_bad;
			arp_cfg_q  <= s_axi_aruser_i;
			arp_id_q   <= s_axi_arid_i;
			arp_addr_q <= s_axi_araddr_i;
			arp_len_q  <= s_axi_arlen_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wst_q <= W_IDLE;
		end else begin
			case (wst_q)
				W_IDLE: if (aw_hs) wst_q <= aw_bad ? W_DISC : W_FWD;
				W_FWD: if (w_take && s_axi_wlast_i) wst_q <= W_IDLE;
				W_DISC: if (disc_take && s_axi_wlast_i) wst_q <= W_IDLE;
				default: wst_q <= W_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (aw_hs) begin
			aw_id_q   <= s_axi_awid_i;
			aw_addr_q <= s_axi_awaddr_i;
			aw_len_q  <= s_axi_awlen_i;
			aw_cfg_q  <= s_axi_awuser_i;
			aw_tag_q  <= free_slot;
			first_q   <= 1'b1;
		end else if (w_take) begin
			first_q   <= 1'b0;
		end
	end

	// Outbound request register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			req_v_q <= 1'b0;
		end else if (w_take || rd_issue) begin
			req_v_q <= 1'b1;
		end else if (req_ready_i) begin
			req_v_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			req_o <= '0;
		end else if (w_take) begin
			req_o <= '{aw_cfg_q ? AXB_CFGWR : AXB_MWR, 8'(aw_tag_q), aw_addr_q,
				aw_len_q, s_axi_wdata_i, s_axi_wlast_i};
		end else if (rd_issue) begin
			req_o <= '{arp_cfg_q ? AXB_CFGRD : AXB_MRD, 8'(free_slot), arp_addr_q,
				arp_len_q, 32'h0000_0000, 1'b1};
		end
	end
	assign req_valid_o = req_v_q;

	// Timers count from the cycle the request is issued
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			iss_q <= '0;
		end else begin
			if (free) iss_q[free_idx] <= 1'b0;
			if (rd_issue) iss_q[free_slot] <= 1'b1;
			if (w_take && first_q && aw_cfg_q) iss_q[aw_tag_q] <= 1'b1;
		end
	end

	// Per-slot config flag picks the timeout source
	always_ff @(posedge mclk_i) begin
		if (alloc) begin
			cfg_q[free_slot] <= alloc_ent.is_cfg;
		end
	end

	axb_tag_table #(.NENT(NENT)) u_tags (
		.mclk_i       (mclk_i),
		.rst_i        (rst_i),
		.alloc_i      (alloc),
		.alloc_ent_i  (alloc_ent),
		.free_i       (free),
		.free_idx_i   (free_idx),
		.own_req_id_i (own_req_id_i),
		.lk_req_id_i  (cpl_i.req_id),
		.lk_tag_i     (cpl_i.tag),
		.rd_idx_i     (tmo_idx),
		.hit_o        (hit),
		.hit_idx_o    (hit_idx),
		.hit_ent_o    (hit_ent),
		.rd_ent_o     (tmo_ent),
		.any_free_o   (any_free),
		.free_slot_o  (free_slot),
		.valid_o      (valid)
	);

	for (genvar g = 0; g < NENT; g++) begin : g_tmr
		axb_cpl_timer #(.TW(TW)) u_tmr (
			.mclk_i    (mclk_i),
			.rst_i     (rst_i),
			.run_i     (valid[g] && iss_q[g]),
			.limit_i   (cfg_q[g] ? TW'(CFG_TMO_CYC) : mem_tmo_cyc_i),
			.expired_o (tmo[g])
		);
	end

	always_comb begin
		tmo_any = |tmo;
		tmo_idx = '0;
		for (int i = NENT - 1; i >= 0; i--) begin
			if (tmo[i]) tmo_idx = IW'(i);
		end
	end

	// Response engine decisions, one event per idle cycle
	assign c_ur   = (cpl_i.status != `AXB_CPL_SC) && (cpl_i.status != `AXB_CPL_CA)
		&& (cpl_i.status != `AXB_CPL_CRS);
	assign c_ca   = cpl_i.status == `AXB_CPL_CA;
	assign d_ib   = (st_q == S_IDLE) && arp_q && arp_bad_q;
	assign d_tmo  = (st_q == S_IDLE) && !d_ib && tmo_any;
	assign d_cpl  = (st_q == S_IDLE) && !d_ib && !tmo_any && cpl_valid_i;
	assign d_unexp = d_cpl && !hit;
	assign d_ur   = d_cpl && hit && c_ur;
	assign d_ca   = d_cpl && hit && c_ca;
	assign d_ep   = d_cpl && hit && !c_ur && !c_ca && cpl_i.poisoned;
	assign free     = d_tmo || (d_cpl && hit);
	assign free_idx = d_tmo ? tmo_idx : hit_idx;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_q <= S_IDLE;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (d_ib) begin
						st_q <= S_RESP;
					end else if (d_tmo) begin
						st_q <= S_RESP;
					end else if (d_cpl) begin
						st_q <= (hit && !hit_ent.is_write && !c_ur && !c_ca
							&& !cpl_i.poisoned) ? S_FWD : S_DROP;
					end
				end
				S_FWD: if (cpl_take && cpl_i.last) st_q <= S_IDLE;
				S_DROP: if (cpl_take && cpl_i.last) st_q <= pend_q ? S_RESP : S_IDLE;
				S_RESP: begin
					if (eng_b_load || (eng_r_load && cnt_q == 8'h00)) st_q <= S_IDLE;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			{cnt_q, rsp_q, id_q, wr_q, pend_q} <= '0;
		end else if (d_ib) begin
			{cnt_q, rsp_q, id_q, wr_q} <= {arp_len_q, `AXB_RESP_SLVERR, arp_id_q, 1'b0};
		end else if (d_tmo) begin
			cnt_q <= tmo_ent.len;
			rsp_q <= TMO_OKAY ? `AXB_RESP_OKAY : `AXB_RESP_SLVERR;
			{id_q, wr_q} <= {tmo_ent.id, tmo_ent.is_write};
		end else if (d_cpl) begin
			pend_q <= hit;
			{cnt_q, id_q, wr_q} <= {hit_ent.len, hit_ent.id, hit_ent.is_write};
			rsp_q <= c_ur ? `AXB_RESP_DECERR : (c_ca || cpl_i.poisoned
				|| cpl_i.status == `AXB_CPL_CRS) ? `AXB_RESP_SLVERR : `AXB_RESP_OKAY;
		end else if (eng_r_load) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	assign cpl_take    = cpl_valid_i && cpl_ready_o;
	assign cpl_ready_o = ((st_q == S_FWD) && r_free) || (st_q == S_DROP);
	assign eng_r_load  = (((st_q == S_FWD) && cpl_valid_i) || ((st_q == S_RESP) && !wr_q))
		&& r_free;
	assign eng_b_load  = (st_q == S_RESP) && wr_q && b_free && !wb_load;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			r_v_q <= 1'b0;
			{s_axi_rid_o, s_axi_rdata_o, s_axi_rresp_o, s_axi_rlast_o} <= '0;
		end else if (eng_r_load) begin
			r_v_q         <= 1'b1;
			s_axi_rid_o   <= id_q;
			s_axi_rdata_o <= (st_q == S_FWD) ? cpl_i.data : `AXB_DATA_ONES;
			s_axi_rresp_o <= (st_q == S_FWD) ? `AXB_RESP_OKAY : rsp_q;
			s_axi_rlast_o <= cnt_q == 8'h00;
		end else if (s_axi_rready_i) begin
			r_v_q <= 1'b0;
		end
	end
	assign s_axi_rvalid_o = r_v_q;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			b_v_q <= 1'b0;
			{s_axi_bid_o, s_axi_bresp_o} <= '0;
		end else if (wb_load) begin
			b_v_q         <= 1'b1;
			s_axi_bid_o   <= aw_id_q;
			s_axi_bresp_o <= disc_take ? `AXB_RESP_SLVERR : `AXB_RESP_OKAY;
		end else if (eng_b_load) begin
			b_v_q         <= 1'b1;
			s_axi_bid_o   <= id_q;
			s_axi_bresp_o <= rsp_q;
		end else if (s_axi_bready_i) begin
			b_v_q <= 1'b0;
		end
	end
	assign s_axi_bvalid_o = b_v_q;

	// Error strobes, one cycle each
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_q <= '0;
		end else begin
			irq_q <= {(ar_hs && ar_bad) || (aw_hs && aw_bad), d_unexp, d_ur, d_tmo,
				d_ep, d_ca};
		end
	end
	assign {illegal_burst_irq_o, unexpected_cpl_irq_o, unsupported_req_irq_o,
		cpl_timeout_irq_o, poisoned_cpl_irq_o, completer_abort_irq_o} = irq_q;

	a_ib_strobe: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ar_hs && ar_bad) |=> illegal_burst_irq_o)
		else $error("illegal read burst gave no strobe");
	a_ib_rd_slverr: assert property (@(posedge mclk_i) disable iff (rst_i)
		d_ib |-> !rd_issue ##1 (st_q == S_RESP && rsp_q == `AXB_RESP_SLVERR && cnt_q == arp_len_q))
		else $error("illegal read burst not answered with SLVERR");
	a_ib_wr_slverr: assert property (@(posedge mclk_i) disable iff (rst_i)
		(disc_take && s_axi_wlast_i) |=> s_axi_bvalid_o && s_axi_bresp_o == `AXB_RESP_SLVERR)
		else $error("illegal write burst not answered with SLVERR");
	a_posted_b: assert property (@(posedge mclk_i) disable iff (rst_i)
		(w_take && s_axi_wlast_i && !aw_cfg_q) |=> s_axi_bvalid_o && s_axi_bresp_o == `AXB_RESP_OKAY)
		else $error("posted write did not finish at once");
	a_unexp_drop: assert property (@(posedge mclk_i) disable iff (rst_i)
		d_unexp |=> unexpected_cpl_irq_o && st_q == S_DROP && !unsupported_req_irq_o)
		else $error("unexpected completion not dropped");
	a_ur_decerr: assert property (@(posedge mclk_i) disable iff (rst_i)
		d_ur |=> unsupported_req_irq_o && rsp_q == `AXB_RESP_DECERR)
		else $error("unsupported request not answered with DECERR");
	a_rsvd_as_ur: assert property (@(posedge mclk_i) disable iff (rst_i)
		(d_cpl && hit && cpl_i.status > `AXB_CPL_CA) |=> unsupported_req_irq_o)
		else $error("reserved status not treated as unsupported");
	a_tmo_end: assert property (@(posedge mclk_i) disable iff (rst_i)
		d_tmo |=> cpl_timeout_irq_o && st_q == S_RESP && !valid[$past(tmo_idx)])
		else $error("timeout did not end the request");
	a_ep_slverr: assert property (@(posedge mclk_i) disable iff (rst_i)
		d_ep |=> poisoned_cpl_irq_o && st_q == S_DROP && rsp_q == `AXB_RESP_SLVERR)
		else $error("poisoned completion mishandled");
	a_ca_slverr: assert property (@(posedge mclk_i) disable iff (rst_i)
		d_ca |=> completer_abort_irq_o && rsp_q == `AXB_RESP_SLVERR)
		else $error("completer abort not answered with SLVERR");
	a_strobe_once: assert property (@(posedge mclk_i) disable iff (rst_i)
		cpl_timeout_irq_o |=> !cpl_timeout_irq_o)
		else $error("timeout strobe longer than one cycle");

	c_good_read: cover property (@(posedge mclk_i) disable iff (rst_i)
		st_q == S_FWD ##[1:20] (s_axi_rvalid_o && s_axi_rlast_o));
	c_timeout: cover property (@(posedge mclk_i) disable iff (rst_i) d_tmo);
	c_unexpected: cover property (@(posedge mclk_i) disable iff (rst_i) d_unexp);
	c_ill_write: cover property (@(posedge mclk_i) disable iff (rst_i) disc_take && s_axi_wlast_i);

endmodule : axb_bridge_err

// ---- verif/axb_cpl_model.sv ----
`timescale 1ns/100ps

// Completer on the link side: one request at a time, fixed answer delay
module axb_cpl_model
	import axb_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] own_req_id_i,
	input  wire logic        req_valid_i,
	output logic             req_ready_o,
	input  wire axb_req_t    req_i,
	output logic             cpl_valid_o,
	input  wire logic        cpl_ready_i,
	output axb_cpl_t         cpl_o,
	input  wire logic [2:0]  st_i,
	input  wire logic        poison_i,
	input  wire logic        mute_i,
	input  wire logic        spur_i
);
	logic       busy_q;
	logic [3:0] dly_q;
	logic [7:0] left_q;
	logic [7:0] tag_q;

	assign req_ready_o = !busy_q;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			busy_q      <= 1'h0;
			cpl_valid_o <= 1'h0;
			dly_q       <= 4'h0;
			left_q      <= 8'h00;
			tag_q       <= 8'h00;
			cpl_o       <= '0;
		end else if (!busy_q) begin
			// Released bus keeps toggling
			cpl_o.data <= ~cpl_o.data;
			if ((req_valid_i && req_i.kind != AXB_MWR && !mute_i) || spur_i) begin
				busy_q <= 1'h1;
				dly_q  <= 4'h3;
				// Tag outside any slot for the stray completion
				tag_q  <= spur_i ? 8'h0b : req_i.tag;
				left_q <= (spur_i || req_i.kind == AXB_CFGWR) ? 8'h00 : req_i.len;
			end
		end else if (dly_q != 4'h0) begin
			dly_q <= dly_q - 4'h1;
			if (dly_q == 4'h1) begin
				cpl_valid_o <= 1'h1;
				cpl_o       <= '{req_id: own_req_id_i, tag: tag_q, status: st_i,
					poisoned: poison_i, data: 32'h5a00_0000, last: (left_q == 8'h00)};
			end
		end else if (cpl_ready_i) begin
			if (left_q == 8'h00) begin
				cpl_valid_o <= 1'h0;
				busy_q      <= 1'h0;
			end else begin
				left_q     <= left_q - 8'h01;
				cpl_o.data <= cpl_o.data + 32'h1;
				cpl_o.last <= (left_q == 8'h01);
			end
		end
	end
endmodule : axb_cpl_model

// ---- verif/axb_bridge_err_tb.sv ----
`timescale 1ns/100ps
`include "axb_consts.svh"

module axb_bridge_err_tb
	import axb_pkg::*;
;
	localparam logic [23:0] CFG_T = 24'h14;
	localparam logic [23:0] MEM_T = 24'h1e;
	logic        mclk_i = 1'h0, rst_i = 1'h1;
	logic [15:0] own_req_id_i = 16'h0100;
	logic [23:0] mem_tmo_cyc_i = MEM_T;
	logic        s_axi_awvalid_i = '0, s_axi_awuser_i = '0, s_axi_wvalid_i = '0;
	logic        s_axi_wlast_i = '0, s_axi_bready_i = '0, s_axi_arvalid_i = '0;
	logic        s_axi_aruser_i = '0, s_axi_rready_i = '0;
	logic [3:0]  s_axi_awid_i = '0, s_axi_arid_i = '0, s_axi_bid_o, s_axi_rid_o;
	logic [31:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0, s_axi_wdata_i = '0, s_axi_rdata_o;
	logic [7:0]  s_axi_awlen_i = '0, s_axi_arlen_i = '0;
	logic [1:0]  s_axi_awburst_i = '0, s_axi_arburst_i = '0, s_axi_bresp_o, s_axi_rresp_o;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic        s_axi_rvalid_o, s_axi_rlast_o, req_valid_o, req_ready_i, cpl_valid_i;
	logic        cpl_ready_o, illegal_burst_irq_o, unexpected_cpl_irq_o;
	logic        unsupported_req_irq_o, cpl_timeout_irq_o, poisoned_cpl_irq_o;
	logic        completer_abort_irq_o, poison = '0, mute = '0, spur = '0;
	logic [2:0]  st = '0;
	axb_req_t    req_o;
	axb_cpl_t    cpl_i;
	axb_req_t    last_req;
	int          n_mismatch = 0, n_checks = 0, n_fwd = 0, irq_n[6], irq_b[6];

	always #4 mclk_i = ~mclk_i;

	axb_bridge_err #(.CFG_TMO_CYC(CFG_T)) dut (.*);
	axb_cpl_model u_cpl (.mclk_i(mclk_i), .rst_i(rst_i), .own_req_id_i(own_req_id_i),
		.req_valid_i(req_valid_o), .req_ready_o(req_ready_i), .req_i(req_o),
		.cpl_valid_o(cpl_valid_i), .cpl_ready_i(cpl_ready_o), .cpl_o(cpl_i), .st_i(st),
		.poison_i(poison), .mute_i(mute), .spur_i(spur));

	// High cycles per strobe, so a long strobe counts twice
	always @(posedge mclk_i) begin : irq_cnt
		logic [5:0] v;
		v = {illegal_burst_irq_o, unexpected_cpl_irq_o, unsupported_req_irq_o,
			cpl_timeout_irq_o, poisoned_cpl_irq_o, completer_abort_irq_o};
		for (int k = 0; k < 6; k++) if (v[k] === 1'h1) irq_n[k]++;
		if (req_valid_o === 1'h1 && req_ready_i === 1'h1) begin
			n_fwd++;
			last_req = req_o;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
		end
	endtask : chk

	task automatic irq_is(input logic [5:0] exp);
		for (int k = 0; k < 6; k++) begin
			chk(irq_n[k] - irq_b[k], exp[k], "strobe count");
			irq_b[k] = irq_n[k];
		end
	endtask : irq_is

	task automatic rd(input logic [1:0] bu, input logic us, input logic [7:0] ln,
		input logic [1:0] er, input logic [31:0] ed, input logic inc, output int cyc);
		int b;
		b = 0;
		cyc = 0;
		@(negedge mclk_i);
		s_axi_arvalid_i = 1'h1;
		s_axi_arburst_i = bu;
		s_axi_aruser_i = us;
		s_axi_arlen_i = ln;
		s_axi_arid_i = 4'h5;
		s_axi_rready_i = 1'h1;
		do @(posedge mclk_i); while (s_axi_arready_o !== 1'h1);
		@(negedge mclk_i) s_axi_arvalid_i = 1'h0;
		while (b <= ln && cyc < 400) begin
			@(posedge mclk_i);
			cyc++;
			if (s_axi_rvalid_o === 1'h1) begin
				chk(s_axi_rresp_o, er, "rresp");
				chk(s_axi_rdata_o, inc ? ed + b : ed, "rdata");
				chk(s_axi_rlast_o, b == ln, "rlast");
				chk(s_axi_rid_o, 4'h5, "rid");
				b++;
			end
		end
		chk(b, ln + 1, "beat count");
		@(negedge mclk_i) s_axi_rready_i = 1'h0;
	endtask : rd

	task automatic wr(input logic [1:0] bu, input logic us, input logic [7:0] ln,
		input logic [1:0] er);
		@(negedge mclk_i);
		s_axi_awvalid_i = 1'h1;
		s_axi_awburst_i = bu;
		s_axi_awuser_i = us;
		s_axi_awlen_i = ln;
		s_axi_awid_i = 4'h3;
		do @(posedge mclk_i); while (s_axi_awready_o !== 1'h1);
		@(negedge mclk_i) s_axi_awvalid_i = 1'h0;
		for (int b = 0; b <= ln; b++) begin
			s_axi_wvalid_i = 1'h1;
			s_axi_wdata_i = 32'hc0de_0000 + b;
			s_axi_wlast_i = (b == ln);
			do @(posedge mclk_i); while (s_axi_wready_o !== 1'h1);
			@(negedge mclk_i);
		end
		s_axi_wvalid_i = 1'h0;
		s_axi_bready_i = 1'h1;
		do @(posedge mclk_i); while (s_axi_bvalid_o !== 1'h1);
		chk(s_axi_bresp_o, er, "bresp");
		chk(s_axi_bid_o, 4'h3, "bid");
		@(negedge mclk_i) s_axi_bready_i = 1'h0;
	endtask : wr

	task automatic t_illegal;
		logic [1:0] bus[3] = '{2'h0, 2'h2, 2'h3};
		int c, f;
		f = n_fwd;
		for (int k = 0; k < 3; k++) begin
			rd(bus[k], 1'h0, 8'h02, `AXB_RESP_SLVERR, `AXB_DATA_ONES, 1'h0, c);
			irq_is(6'b100000);
			wr(bus[k], 1'h0, 8'h01, `AXB_RESP_SLVERR);
			irq_is(6'b100000);
		end
		chk(n_fwd - f, 0, "forwarded");
		$display("t_illegal done");
	endtask : t_illegal

	task automatic t_plain;
		int c, f;
		f = n_fwd;
		wr(`AXB_BURST_INCR, 1'h0, 8'h02, `AXB_RESP_OKAY);
		chk(n_fwd - f, 3, "posted beats");
		chk(last_req.data, 32'hc0de_0002, "posted data");
		chk(last_req.kind, AXB_MWR, "posted kind");
		rd(`AXB_BURST_INCR, 1'h0, 8'h03, `AXB_RESP_OKAY, 32'h5a00_0000, 1'h1, c);
		rd(`AXB_BURST_INCR, 1'h1, 8'h00, `AXB_RESP_OKAY, 32'h5a00_0000, 1'h1, c);
		chk(last_req.kind, AXB_CFGRD, "cfg read kind");
		wr(`AXB_BURST_INCR, 1'h1, 8'h00, `AXB_RESP_OKAY);
		chk(last_req.kind, AXB_CFGWR, "cfg write kind");
		irq_is(6'b000000);
		$display("t_plain done");
	endtask : t_plain

	task automatic t_status;
		logic [2:0] sts[7] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h7, 3'h4, 3'h0};
		int c;
		for (int k = 0; k < 7; k++) begin
			st = sts[k];
			poison = (k == 6);
			rd(`AXB_BURST_INCR, 1'h0, 8'h01, k < 5 ? `AXB_RESP_DECERR : `AXB_RESP_SLVERR,
				`AXB_DATA_ONES, 1'h0, c);
			irq_is(k < 5 ? 6'b001000 : k == 5 ? 6'b000001 : 6'b000010);
		end
		st = 3'h0;
		poison = 1'h0;
		$display("t_status done");
	endtask : t_status

	task automatic t_unexp;
		int c;
		@(negedge mclk_i) spur = 1'h1;
		@(negedge mclk_i) spur = 1'h0;
		repeat (12) @(negedge mclk_i);
		irq_is(6'b010000);
		rd(`AXB_BURST_INCR, 1'h0, 8'h01, `AXB_RESP_OKAY, 32'h5a00_0000, 1'h1, c);
		irq_is(6'b000000);
		$display("t_unexp done");
	endtask : t_unexp

	task automatic t_tmo;
		int c;
		mute = 1'h1;
		rd(`AXB_BURST_INCR, 1'h0, 8'h01, `AXB_RESP_OKAY, `AXB_DATA_ONES, 1'h0, c);
		chk(c >= MEM_T && c <= MEM_T + 12, 1, "mem wait");
		irq_is(6'b000100);
		rd(`AXB_BURST_INCR, 1'h1, 8'h00, `AXB_RESP_OKAY, `AXB_DATA_ONES, 1'h0, c);
		chk(c >= CFG_T && c <= CFG_T + 12, 1, "cfg wait");
		irq_is(6'b000100);
		mute = 1'h0;
		$display("t_tmo done");
	endtask : t_tmo

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i) rst_i = 1'h0;
		t_illegal();
		t_plain();
		t_status();
		t_unexp();
		t_tmo();
		end_of_test();
	end

	// Whole run needs a few hundred cycles; the watchdog allows 12500
	initial begin
		#100000;
		n_mismatch++;
		$display("watchdog expired");
		end_of_test();
	end
endmodule : axb_bridge_err_tb
